//--- verilog/dspace_pkg.sv
// Purpose: shared constants and types for the data space steering block
// Assumes: 50 MHz core clock, special registers reached by direct addressing
// Notes:   six timing constants, others are offsets, fields, reset values and sizes
package dspace_pkg;
  // special register offsets
  localparam logic [7:0] AUX1_ADDR  = 8'ha2;
  localparam logic [7:0] AUXC_ADDR  = 8'h8e;
  localparam logic [7:0] PLO_ADDR   = 8'h82;
  localparam logic [7:0] PHI_ADDR   = 8'h83;
  // field positions
  localparam int SEL_BIT   = 0;
  localparam int FLAG_BIT  = 3;
  localparam int STEER_BIT = 1;
  // reset values
  localparam logic       SEL_RST   = 1'b0;
  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       STEER_RST = 1'b0;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  // memory sizes
  localparam int EXPANDED_RAM_SMALL = 256;
  localparam int EXPANDED_RAM_LARGE = 768;
  // timing
  localparam int CLK_NS      = 20;
  localparam int STROBE_NS   = 60;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [2:0] STRB_LEN   = 3'(STROBE_CYC + SYNC_STAGES);
  localparam logic [2:0] ALE_PERIOD = 3'h6;

  typedef enum logic [2:0] {
    K_DIRECT, K_INDIRECT, K_STACK, K_EXTERNAL_MOVE_OP_IDX, K_EXTERNAL_MOVE_OP_PTR
  } access_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_LATCH, ST_STRB, ST_DONE
  } bus_state_type;
endpackage

//--- verilog/ext_bus_if.sv
// Purpose: carrier between the steering logic and the external bus engine
// Assumes: single clock domain
// Notes:   pin drives live here so the engine flops feed the top ports
`timescale 1ns/100ps
interface ext_bus_if;
  logic        start;
  logic        wr;
  logic        use_p2;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        done;
  logic        busy;
  logic        ale_req;
  logic [7:0]  p0_out;
  logic        p0_oe;
  logic [7:0]  p2_out;
  logic        p2_oe;
  logic        wr_n;
  logic        rd_n;
  modport eng (input start, wr, use_p2, addr, wdata,
               output rdata, done, busy, ale_req, p0_out, p0_oe, p2_out, p2_oe, wr_n, rd_n);
  modport ctl (output start, wr, use_p2, addr, wdata,
               input rdata, done, busy, ale_req, p0_out, p0_oe, p2_out, p2_oe, wr_n, rd_n);
endinterface

//--- verilog/ext_bus_cycle.sv
// Purpose: one multiplexed external data bus cycle per start
// Assumes: start only while idle
// Notes:   read data is sampled through a two stage synchroniser
`timescale 1ns/100ps
module ext_bus_cycle
  import dspace_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // pin input
  input  wire logic [7:0] i_p0_in,
  // carrier
  ext_bus_if.eng          bus
);
  bus_state_type state_q;
  logic [2:0]  cnt_q;
  logic [7:0]  s1_q, s2_q, rdata_q, p0_out_q, p2_out_q, wdata_q;
  logic        wr_q, p0_oe_q, p2_oe_q, wr_n_q, rd_n_q, done_q;

  assign bus.ale_req = (state_q == ST_ADDR);
  assign bus.busy    = (state_q != ST_IDLE);
  assign bus.done    = done_q;
  assign bus.rdata   = rdata_q;
  assign bus.p0_out  = p0_out_q;
  assign bus.p0_oe   = p0_oe_q;
  assign bus.p2_out  = p2_out_q;
  assign bus.p2_oe   = p2_oe_q;
  assign bus.wr_n    = wr_n_q;
  assign bus.rd_n    = rd_n_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      {s1_q, s2_q, rdata_q, p0_out_q, p2_out_q, wdata_q} <= {6{BYTE_RST}};
      {wr_q, p0_oe_q, p2_oe_q, done_q} <= 4'h0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      s1_q <= i_p0_in;
      s2_q <= s1_q;
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: if (bus.start) begin
          // high byte on port 2, low byte on port 0
          // index moves leave port 2 undriven
          state_q <= ST_ADDR;
          wr_q <= bus.wr;
          wdata_q <= bus.wdata;
          p0_out_q <= bus.addr[7:0];
          p0_oe_q <= 1'b1;
          p2_out_q <= bus.addr[15:8];
          p2_oe_q <= bus.use_p2;
        end
        ST_ADDR: state_q <= ST_LATCH;
        ST_LATCH: begin
          state_q <= ST_STRB;
          cnt_q <= STRB_LEN - 3'h1;
          p0_oe_q <= wr_q;
          p0_out_q <= wdata_q;
          wr_n_q <= ~wr_q;
          rd_n_q <= wr_q;
        end
        ST_STRB: if (cnt_q == 3'h0) begin
          state_q <= ST_DONE;
          wr_n_q <= 1'b1;
          rd_n_q <= 1'b1;
          rdata_q <= s2_q;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 3'h1;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
          p0_oe_q <= 1'b0;
          p2_oe_q <= 1'b0;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_addr_phase;
    (state_q == ST_ADDR) ##1 (state_q == ST_LATCH);
  endsequence
  sequence s_strobe_phase;
    (state_q == ST_STRB) [*5] ##1 (state_q == ST_DONE);
  endsequence

  a_cycle_shape: assert property (
    bus.start && !bus.busy |=> s_addr_phase ##1 s_strobe_phase)
    else $error("bus cycle did not follow address then strobe phases");
  a_strobe_dir: assert property (
    state_q == ST_STRB |-> (wr_n_q == ~wr_q) && (rd_n_q == wr_q))
    else $error("strobe does not match access direction");
  a_p2_free: assert property (
    bus.start && !bus.busy && !bus.use_p2 |=> !p2_oe_q [*8])
    else $error("port 2 driven on an index move");
  a_p2_high: assert property (
    bus.start && !bus.busy && bus.use_p2 |=> p2_oe_q && p2_out_q == $past(bus.addr[15:8]))
    else $error("port 2 lacks the pointer high byte");
endmodule

//--- verilog/data_space_steer.sv
// Purpose: data memory steering with dual data pointer and expanded ram
// Assumes: core issues one request at a time, waits for o_done
// Notes:   special registers here answer direct reads; others read zero
`timescale 1ns/100ps

// Operation
// - two independent 16-bit data pointers, pointer_select picks one.
// - pointer_select is bit 0 of aux_reg_one at a2h, reset zero.
// - user_flag_bit is a plain read/write flag, reset zero.
// - increment of aux_reg_one toggles pointer_select.
// - on-chip expanded_ram of 256 or 768 bytes, sized by parameter.
// - internal addresses 00h-7fh reached by direct and indirect modes.
// - indirect 80h-ffh reaches the upper ram bank.
// - direct 80h-ffh reaches special registers only.
// - steer 0 in-range moves use on-chip ram, pins untouched.
// - steer 0 pointer moves above range run an external bus cycle.
// - expanded_ram above ffh reachable only through the data pointer.
// - steer 1 index moves put 8-bit address on port 0, port 2 free.
// - pointer bus access drives high byte on port 2, low on port 0.
// - external cycles strobe write or read pin.
// - stack accesses reach internal ram only, never expanded_ram.
// - one address latch pulse skipped per external data access.
module data_space_steer
  import dspace_pkg::*;
#(
  parameter int EXPANDED_RAM_BYTES = EXPANDED_RAM_SMALL
) (
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_nrst,
  // core request
  input  wire logic            i_req,
  input  wire access_kind_type i_kind,
  input  wire logic            i_wr,
  input  wire logic            i_inc,
  input  wire logic [7:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  // core pointer operations
  input  wire logic            i_ptr_load,
  input  wire logic            i_ptr_inc,
  input  wire logic [15:0]     i_ptr_wdata,
  // core answer
  output logic [7:0]           o_rdata,
  output logic                 o_done,
  output logic                 o_busy,
  output logic                 o_pointer_select,
  output logic                 o_ext_steer,
  // external bus pins
  input  wire logic [7:0]      i_p0_in,
  output logic [7:0]           o_p0_out,
  output logic                 o_p0_oe,
  output logic [7:0]           o_p2_out,
  output logic                 o_p2_oe,
  output logic                 o_wr_n,
  output logic                 o_rd_n,
  output logic                 o_ale
);
  localparam int XA_W = $clog2(EXPANDED_RAM_BYTES);
  localparam logic [16:0] XLIM = 17'(EXPANDED_RAM_BYTES);

  ext_bus_if bus ();

  logic [7:0]  iram_q [256];
  logic [7:0]  expanded_ram_q [EXPANDED_RAM_BYTES];
  logic [15:0] ptr_q  [2];
  logic        sel_q, flag_q, steer_q, busy_q, done_q, skip_q, ale_q;
  logic [7:0]  rdata_q;
  logic [2:0]  ale_cnt_q;

  // decode
  wire        accept    = i_req && !busy_q;
  wire        is_direct = (i_kind == K_DIRECT);
  wire        is_external_move_op   = (i_kind == K_EXTERNAL_MOVE_OP_IDX) || (i_kind == K_EXTERNAL_MOVE_OP_PTR);
  // stack shares the indirect path into internal ram
  wire        is_ind    = (i_kind == K_INDIRECT) || (i_kind == K_STACK);
  // direct upper half is special register space
  wire        is_sfr    = is_direct && i_addr[7];
  // indirect upper half to the upper bank
  wire        iram_hit  = (is_direct && !i_addr[7]) || is_ind;
  wire [15:0] sel_ptr   = ptr_q[sel_q];
  // index moves carry only 8 address bits
  wire [15:0] xaddr     = (i_kind == K_EXTERNAL_MOVE_OP_PTR) ? sel_ptr : {8'h00, i_addr};
  // in-range moves with steer clear stay on chip
  wire        expanded_ram_hit  = is_external_move_op && !steer_q && ({1'b0, xaddr} < XLIM);
  // everything else goes to the pins
  wire        ext_hit   = is_external_move_op && !expanded_ram_hit;
  wire        iram_we   = accept && i_wr && iram_hit;
  wire        expanded_ram_we   = accept && i_wr && expanded_ram_hit;
  wire        sfr_we    = accept && i_wr && is_sfr;
  wire        aux1_we   = sfr_we && (i_addr == AUX1_ADDR);
  wire        aux1_inc  = accept && i_inc && is_sfr && (i_addr == AUX1_ADDR);
  wire        auxc_we   = sfr_we && (i_addr == AUXC_ADDR);
  wire        plo_we    = sfr_we && (i_addr == PLO_ADDR);
  wire        phi_we    = sfr_we && (i_addr == PHI_ADDR);
  wire        ext_start = accept && ext_hit;
  wire        ale_tick  = (ale_cnt_q == 3'h0);
  // restart at each bus cycle so no regular pulse lands in the data phase
  wire        ale_restart = ale_tick || ext_start;

  wire [7:0] aux1_rd = {4'h0, flag_q, 2'b00, sel_q};
  wire [7:0] auxc_rd = {6'h00, steer_q, 1'b0};
  wire [7:0] sfr_rd  = (i_addr == AUX1_ADDR) ? aux1_rd :
                       (i_addr == AUXC_ADDR) ? auxc_rd :
                       (i_addr == PLO_ADDR)  ? sel_ptr[7:0] :
                       (i_addr == PHI_ADDR)  ? sel_ptr[15:8] : BYTE_RST;
  wire [7:0] rdata_d = iram_hit ? iram_q[i_addr] :
                       expanded_ram_hit ? expanded_ram_q[xaddr[XA_W-1:0]] :
                       is_sfr   ? sfr_rd : BYTE_RST;

  assign bus.start  = ext_start;
  assign bus.wr     = i_wr;
  // pointer moves use port 2 for the high byte
  assign bus.use_p2 = (i_kind == K_EXTERNAL_MOVE_OP_PTR);
  assign bus.addr   = xaddr;
  assign bus.wdata  = i_wdata;

  ext_bus_cycle u_bus (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_p0_in (i_p0_in),
    .bus     (bus)
  );

  // two pointers, one update path each
  for (genvar g = 0; g < 2; g++) begin : g_ptr
    wire me = (sel_q == 1'(g));
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        ptr_q[g] <= 16'h0000;
      end else if (me && i_ptr_load) begin
        ptr_q[g] <= i_ptr_wdata;
      end else if (me && i_ptr_inc) begin
        ptr_q[g] <= ptr_q[g] + 16'h0001;
      end else if (me && plo_we) begin
        ptr_q[g][7:0] <= i_wdata;
      end else if (me && phi_we) begin
        ptr_q[g][15:8] <= i_wdata;
      end
    end
  end

  // memories: no reset, contents undefined at power up
  always_ff @(posedge i_mclk) begin
    if (iram_we) begin
      iram_q[i_addr] <= i_wdata;
    end
    if (expanded_ram_we) begin
      expanded_ram_q[xaddr[XA_W-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q <= SEL_RST;
      flag_q <= FLAG_RST;
      steer_q <= STEER_RST;
    end else begin
      if (aux1_inc) begin
        sel_q <= ~sel_q;
      end else if (aux1_we) begin
        sel_q <= i_wdata[SEL_BIT];
        flag_q <= i_wdata[FLAG_BIT];
      end
      if (auxc_we) begin
        steer_q <= i_wdata[STEER_BIT];
      end
    end
  end

  // answer path; requests while busy are dropped
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= BYTE_RST;
    end else begin
      done_q <= (accept && !ext_hit) || bus.done;
      if (ext_start) begin
        busy_q <= 1'b1;
      end else if (bus.done) begin
        busy_q <= 1'b0;
      end
      if (accept && !ext_hit) begin
        rdata_q <= rdata_d;
      end else if (bus.done) begin
        rdata_q <= bus.rdata;
      end
    end
  end

  // free running latch pulse, one skipped per external access
  // set wins over the clear so a start on a tick is never lost
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ale_cnt_q <= 3'h0;
      skip_q <= 1'b0;
      ale_q <= 1'b0;
    end else begin
      ale_cnt_q <= ale_restart ? (ALE_PERIOD - 3'h1) : (ale_cnt_q - 3'h1);
      skip_q <= ext_start || (skip_q && !ale_tick);
      ale_q <= (ale_tick && !skip_q && !ext_start) || bus.ale_req;
    end
  end

  assign o_rdata          = rdata_q;
  assign o_done           = done_q;
  assign o_busy           = busy_q;
  assign o_pointer_select = sel_q;
  assign o_ext_steer      = steer_q;
  assign o_p0_out         = bus.p0_out;
  assign o_p0_oe          = bus.p0_oe;
  assign o_p2_out         = bus.p2_out;
  assign o_p2_oe          = bus.p2_oe;
  assign o_wr_n           = bus.wr_n;
  assign o_rd_n           = bus.rd_n;
  assign o_ale            = ale_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_unsel_hold: assert property (
    i_ptr_load && !sel_q |=> ptr_q[1] == $past(ptr_q[1]))
    else $error("unselected pointer changed on load");
  a_sel_toggle: assert property (
    aux1_inc |=> sel_q == !$past(sel_q) && flag_q == $past(flag_q))
    else $error("increment did not toggle pointer select");
  a_flag_write: assert property (
    aux1_we && !aux1_inc |=> flag_q == $past(i_wdata[FLAG_BIT]))
    else $error("user flag did not take written value");
  a_expanded_ram_quiet: assert property (
    accept && expanded_ram_hit && !busy_q |=> o_wr_n && o_rd_n && !o_p0_oe && !busy_q)
    else $error("on-chip move touched bus pins");
  a_sfr_direct: assert property (
    accept && is_direct && i_addr[7] |-> !iram_we)
    else $error("direct upper access reached ram");
  a_upper_bank: assert property (
    iram_we && is_ind && i_addr[7] |=> iram_q[$past(i_addr)] == $past(i_wdata))
    else $error("indirect upper write missed ram bank");
  a_ale_skip: assert property (
    ale_tick && skip_q && !bus.ale_req |=> !o_ale)
    else $error("latch pulse not skipped during access");
  a_ext_done: assert property (
    ext_start |-> ##9 (o_done && !o_busy))
    else $error("external access did not finish in nine cycles");

  sequence s_busy_run;
    o_busy [*8];
  endsequence
  sequence s_busy_end;
    o_done && !o_busy;
  endsequence

  a_sel_write: assert property (
    aux1_we && !aux1_inc |=> sel_q == $past(i_wdata[SEL_BIT]))
    else $error("pointer select did not take written value");
  a_steer_write: assert property (
    auxc_we |=> steer_q == $past(i_wdata[STEER_BIT]))
    else $error("ram steer did not take written value");
  a_ptr_load: assert property (
    i_ptr_load |=> ptr_q[$past(sel_q)] == $past(i_ptr_wdata))
    else $error("selected pointer missed its load");
  a_ptr_inc: assert property (
    i_ptr_inc && !i_ptr_load |=> ptr_q[$past(sel_q)] == $past(ptr_q[sel_q]) + 16'h0001)
    else $error("selected pointer missed its increment");
  a_unsel_zero: assert property (
    i_ptr_load && sel_q |=> ptr_q[0] == $past(ptr_q[0]))
    else $error("unselected pointer changed on load");
  a_stack_iram: assert property (
    accept && i_wr && (i_kind == K_STACK) |=> iram_q[$past(i_addr)] == $past(i_wdata))
    else $error("stack write missed internal ram");
  a_expanded_ram_write: assert property (
    expanded_ram_we |=> expanded_ram_q[$past(xaddr[XA_W-1:0])] == $past(i_wdata))
    else $error("expanded ram write lost");
  a_ptr_addr: assert property (
    ext_start && (i_kind == K_EXTERNAL_MOVE_OP_PTR) |=> o_p0_oe && o_p2_oe &&
      (o_p0_out == $past(sel_ptr[7:0])) && (o_p2_out == $past(sel_ptr[15:8])))
    else $error("pointer address missing from ports");
  a_idx_addr: assert property (
    ext_start && (i_kind == K_EXTERNAL_MOVE_OP_IDX) |=> o_p0_oe && !o_p2_oe && (o_p0_out == $past(i_addr)))
    else $error("index address wrong or port 2 driven");
  a_int_answer: assert property (
    accept && !ext_hit |=> o_done && !o_busy)
    else $error("internal access did not answer next cycle");
  a_ext_window: assert property (
    ext_start |=> s_busy_run ##1 s_busy_end)
    else $error("external access busy window wrong");
  a_read_data: assert property (
    bus.done |=> o_rdata == $past(bus.rdata))
    else $error("external read data not handed over");
  a_steer_route: assert property (
    accept && is_external_move_op && steer_q |=> o_busy)
    else $error("steered move did not go to the pins");
endmodule

//--- verification/ext_mem_model.sv
// Purpose: external data memory on the multiplexed port 0 / port 2 bus
// Assumes: address taken while ale high and port 0 driven
// Notes:   released bus shows inverse of last value, not a held copy
`timescale 1ns/100ps
module ext_mem_model #(
  parameter int SLOW = 0
) (
  // clock
  input  wire logic       i_mclk,
  // bus from device
  input  wire logic [7:0] i_p0_drv,
  input  wire logic       i_p0_oe,
  input  wire logic [7:0] i_p2_drv,
  input  wire logic       i_p2_oe,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_ale,
  // answer on port 0
  output logic [7:0]      o_p0_drv
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0]  last_q;
  int          latch_cnt;
  int          rd_cnt;
  initial begin
    addr_q    = 16'h0000;
    last_q    = 8'h00;
    latch_cnt = 0;
    rd_cnt    = 0;
  end
  // high byte only when port 2 driven
  always @(posedge i_mclk) begin
    if (i_ale && i_p0_oe) begin
      addr_q    <= {(i_p2_oe ? i_p2_drv : 8'h00), i_p0_drv};
      latch_cnt <= latch_cnt + 1;
    end
    if (!i_wr_n) mem[addr_q] <= i_p0_drv;
    rd_cnt <= !i_rd_n ? rd_cnt + 1 : 0;
    if (!i_rd_n) last_q <= o_p0_drv;
  end
  // slow memory: data valid only SLOW cycles into the strobe
  assign o_p0_drv = (!i_rd_n && rd_cnt >= SLOW) ? mem[addr_q] : ~last_q;
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench for the data space steering block
// Assumes: 768 byte expanded ram, slow external memory
// Notes:   inputs change on the falling edge only
`timescale 1ns/100ps
module tb;
  import dspace_pkg::*;
  logic            i_mclk, i_nrst, i_req, i_wr, i_inc;
  logic            i_ptr_load, i_ptr_inc;
  access_kind_type i_kind;
  logic [7:0]      i_addr, i_wdata, o_rdata, o_p0_out, o_p2_out, mem_drv, p0_wire;
  logic [15:0]     i_ptr_wdata;
  logic            o_done, o_busy, o_pointer_select, o_ext_steer;
  logic            o_p0_oe, o_p2_oe, o_wr_n, o_rd_n, o_ale, p2_hit;
  int              fail_count, n_tests, act;

  data_space_steer #(.EXPANDED_RAM_BYTES(EXPANDED_RAM_LARGE)) data_space_steer_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(i_req), .i_kind(i_kind),
    .i_wr(i_wr), .i_inc(i_inc), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_ptr_load(i_ptr_load), .i_ptr_inc(i_ptr_inc), .i_ptr_wdata(i_ptr_wdata),
    .o_rdata(o_rdata), .o_done(o_done), .o_busy(o_busy),
    .o_pointer_select(o_pointer_select), .o_ext_steer(o_ext_steer),
    .i_p0_in(p0_wire), .o_p0_out(o_p0_out), .o_p0_oe(o_p0_oe),
    .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe), .o_wr_n(o_wr_n),
    .o_rd_n(o_rd_n), .o_ale(o_ale));

  ext_mem_model #(.SLOW(2)) ext_mem_model_i (
    .i_mclk(i_mclk), .i_p0_drv(o_p0_out), .i_p0_oe(o_p0_oe),
    .i_p2_drv(o_p2_out), .i_p2_oe(o_p2_oe), .i_wr_n(o_wr_n),
    .i_rd_n(o_rd_n), .i_ale(o_ale), .o_p0_drv(mem_drv));

  // port 0 level from both parties
  assign p0_wire = o_p0_oe ? o_p0_out : mem_drv;

  always #10 i_mclk = ~i_mclk;

  // pin activity seen by the outside world
  always @(posedge i_mclk) begin
    if (o_p2_oe) p2_hit = 1'b1;
    if (!o_wr_n || !o_rd_n || o_p0_oe || o_p2_oe) act++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one request, waits for done; lat is the expected answer cycle
  task automatic req(input access_kind_type k, input logic w, input logic n,
                     input logic [7:0] a, input logic [7:0] d, input int lat,
                     output logic [7:0] q);
    int c;
    @(negedge i_mclk);
    i_kind  = k;
    i_wr    = w;
    i_inc   = n;
    i_addr  = a;
    i_wdata = d;
    i_req   = 1'b1;
    @(negedge i_mclk);
    i_req = 1'b0;
    c = 1;
    chk(o_busy, 16'(lat > 1));
    while (o_done !== 1'b1 && c < 20) begin
      @(negedge i_mclk);
      c++;
    end
    chk(16'(c), 16'(lat));
    q = o_rdata;
  endtask

  task automatic ptr(input logic l, input logic n, input logic [15:0] v);
    @(negedge i_mclk);
    i_ptr_load  = l;
    i_ptr_inc   = n;
    i_ptr_wdata = v;
    @(negedge i_mclk);
    i_ptr_load = 1'b0;
    i_ptr_inc  = 1'b0;
  endtask

  task automatic set_reg(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    req(K_DIRECT, 1'b1, 1'b0, a, v, 1, q);
  endtask

  task automatic t_reset;
    logic [7:0] q;
    chk(o_pointer_select, 16'h0);
    chk(o_ext_steer, 16'h0);
    req(K_DIRECT, 1'b0, 1'b0, AUX1_ADDR, 8'h00, 1, q);
    chk(q & 8'h09, 16'h0);
    $display("t_reset done");
  endtask

  task automatic t_aux;
    logic [7:0] q;
    set_reg(AUX1_ADDR, 8'h08);
    chk(o_pointer_select, 16'h0);
    req(K_DIRECT, 1'b0, 1'b1, AUX1_ADDR, 8'h00, 1, q);
    chk(o_pointer_select, 16'h1);
    req(K_DIRECT, 1'b0, 1'b0, AUX1_ADDR, 8'h00, 1, q);
    chk(q & 8'h09, 16'h9);
    req(K_DIRECT, 1'b0, 1'b1, AUX1_ADDR, 8'h00, 1, q);
    chk(o_pointer_select, 16'h0);
    set_reg(AUX1_ADDR, 8'h01);
    chk(o_pointer_select, 16'h1);
    $display("t_aux done");
  endtask

  task automatic t_ptr;
    logic [7:0] q;
    set_reg(AUX1_ADDR, 8'h00);
    ptr(1'b1, 1'b0, 16'h1234);
    set_reg(AUX1_ADDR, 8'h01);
    ptr(1'b1, 1'b0, 16'h0aff);
    ptr(1'b0, 1'b1, 16'h0000);
    req(K_DIRECT, 1'b0, 1'b0, PLO_ADDR, 8'h00, 1, q);
    chk(q, 16'h00);
    req(K_DIRECT, 1'b0, 1'b0, PHI_ADDR, 8'h00, 1, q);
    chk(q, 16'h0b);
    set_reg(AUX1_ADDR, 8'h00);
    req(K_DIRECT, 1'b0, 1'b0, PLO_ADDR, 8'h00, 1, q);
    chk(q, 16'h34);
    req(K_DIRECT, 1'b0, 1'b0, PHI_ADDR, 8'h00, 1, q);
    chk(q, 16'h12);
    $display("t_ptr done");
  endtask

  task automatic t_iram;
    logic [7:0] q;
    req(K_DIRECT, 1'b1, 1'b0, 8'h10, 8'h5a, 1, q);
    req(K_INDIRECT, 1'b0, 1'b0, 8'h10, 8'h00, 1, q);
    chk(q, 16'h5a);
    req(K_INDIRECT, 1'b1, 1'b0, 8'h90, 8'hc3, 1, q);
    req(K_DIRECT, 1'b1, 1'b0, 8'h90, 8'h77, 1, q);
    req(K_INDIRECT, 1'b0, 1'b0, 8'h90, 8'h00, 1, q);
    chk(q, 16'hc3);
    req(K_DIRECT, 1'b0, 1'b0, 8'h90, 8'h00, 1, q);
    chk(q, 16'h00);
    req(K_STACK, 1'b1, 1'b0, 8'ha0, 8'h3c, 1, q);
    req(K_EXTERNAL_MOVE_OP_IDX, 1'b1, 1'b0, 8'ha0, 8'h11, 1, q);
    req(K_STACK, 1'b0, 1'b0, 8'ha0, 8'h00, 1, q);
    chk(q, 16'h3c);
    $display("t_iram done");
  endtask

  task automatic t_expanded_ram;
    logic [7:0] q;
    int         a0;
    a0 = act;
    req(K_EXTERNAL_MOVE_OP_IDX, 1'b1, 1'b0, 8'h40, 8'h21, 1, q);
    ptr(1'b1, 1'b0, 16'h02ff);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b1, 1'b0, 8'h00, 8'h99, 1, q);
    req(K_EXTERNAL_MOVE_OP_IDX, 1'b0, 1'b0, 8'h40, 8'h00, 1, q);
    chk(q, 16'h21);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b0, 1'b0, 8'h00, 8'h00, 1, q);
    chk(q, 16'h99);
    chk(16'(act - a0), 16'h0);
    $display("t_expanded_ram done");
  endtask

  task automatic t_ext;
    logic [7:0] q;
    int         l0;
    l0 = ext_mem_model_i.latch_cnt;
    ptr(1'b1, 1'b0, 16'h0300);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b1, 1'b0, 8'h00, 8'h5c, 9, q);
    chk(ext_mem_model_i.mem[16'h0300], 16'h5c);
    ptr(1'b1, 1'b0, 16'h1357);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b1, 1'b0, 8'h00, 8'ha5, 9, q);
    chk(ext_mem_model_i.addr_q, 16'h1357);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b0, 1'b0, 8'h00, 8'h00, 9, q);
    chk(q, 16'ha5);
    set_reg(AUXC_ADDR, 8'h02);
    chk(o_ext_steer, 16'h1);
    p2_hit = 1'b0;
    req(K_EXTERNAL_MOVE_OP_IDX, 1'b1, 1'b0, 8'h66, 8'he7, 9, q);
    chk(ext_mem_model_i.mem[16'h0066], 16'he7);
    chk(p2_hit, 16'h0);
    ptr(1'b1, 1'b0, 16'h0250);
    req(K_EXTERNAL_MOVE_OP_PTR, 1'b1, 1'b0, 8'h00, 8'h4b, 9, q);
    chk(ext_mem_model_i.mem[16'h0250], 16'h4b);
    chk(16'(ext_mem_model_i.latch_cnt - l0), 16'h5);
    set_reg(AUXC_ADDR, 8'h00);
    $display("t_ext done");
  endtask

  initial begin
    i_mclk      = 1'b0;
    i_nrst      = 1'b0;
    i_req       = 1'b0;
    i_wr        = 1'b0;
    i_inc       = 1'b0;
    i_kind      = K_DIRECT;
    i_addr      = 8'h00;
    i_wdata     = 8'h00;
    i_ptr_load  = 1'b0;
    i_ptr_inc   = 1'b0;
    i_ptr_wdata = 16'h0000;
    fail_count  = 0;
    n_tests     = 0;
    act         = 0;
    p2_hit      = 1'b0;
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
    i_nrst = 1'b1;
    t_reset();
    t_aux();
    t_ptr();
    t_iram();
    t_expanded_ram();
    t_ext();
    end_sim();
  end

  // tests need well under 1000 cycles
  initial begin
    #(20 * 4000);
    fail_count++;
    $display("FAIL watchdog expired at t=%0t", $time);
    end_sim();
  end
endmodule
